// File: rtl/fast_eth_rx_symbol_decode.sv
// 100 Mb/s receive symbol decoder with carrier sense and collision
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - invalid groups give nibble 6 with error
// - alternate map bit gives nibble 5 instead
// - control groups inside data count as invalid
// - lookup table maps groups to nibbles
// - idle then start pair becomes preamble pair
// - decode whole packet until end pair or idle pair
// - half duplex collision on receive plus transmit
// - full duplex never asserts collision
// - two separated zeros in ten bits raise carrier
// - half duplex carrier on transmit or receive
// - full duplex carrier only on receive
// - idle pair drops carrier
// - repeater mode carrier from receive only
// - follow standard receive control sequence
// - idle group is 11111
// - first start group is 11000
// - second start group is 10001
// - end pair is 01101 then 00111
module fast_eth_rx_symbol_decode (
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    input  wire logic       i_rx_bit,
    input  wire logic       i_rx_bit_strobe,
    input  wire logic       i_full_duplex,
    input  wire logic       i_tx_active,
    input  wire logic       i_repeater_pin,
    input  wire logic       i_repeater_ctrl,
    input  wire logic       i_alt_invalid_map,
    input  wire logic       i_rx_ready,
    output logic            o_bit_ready,
    output logic [3:0]      o_rxd,
    output logic            o_rx_dv,
    output logic            o_rx_er,
    output logic            o_rx_valid,
    output logic            o_crs,
    output logic            o_col
);

    typedef struct packed {
        logic [rx_decode_pkg::SYNC_W-1:0]   sync1;
        logic [rx_decode_pkg::SYNC_W-1:0]   sync2;
        logic [rx_decode_pkg::HIST_W-1:0]   sh;
        rx_decode_pkg::rx_state_e           st;
        logic [2:0]                         bitcnt;
        logic                               prev_idle;
        logic                               carrier;
        logic                               pend_valid;
        logic [rx_decode_pkg::WORD_W-1:0]   pend_word;
        logic                               out_valid;
        logic [rx_decode_pkg::WORD_W-1:0]   out_word;
        logic                               bit_ready;
        logic                               crs;
        logic                               col;
    } rx_s;

    rx_s                                s;
    rx_s                                next_s;
    logic                               take;
    logic                               boundary;
    logic [rx_decode_pkg::HIST_W-1:0]   new_sh;
    logic [4:0]                         grp;
    logic [4:0]                         dec;
    logic [3:0]                         inv;
    logic                               fd;
    logic                               txa;
    logic                               rptr;
    logic                               push_valid;
    logic [rx_decode_pkg::WORD_W-1:0]   push_word;
    logic                               fifo_in_ready;
    logic                               fifo_af;
    logic                               fifo_out_valid;
    logic [rx_decode_pkg::WORD_W-1:0]   fifo_out_data;
    logic                               fifo_out_ready;

    // position of the valid flag in a lookup result
    localparam int NIBBLE_IDX = rx_decode_pkg::NIBBLE_W;

    // outputs straight from state flops
    assign o_bit_ready = s.bit_ready;
    assign o_rxd       = s.out_word[3:0];
    assign o_rx_dv     = s.out_word[rx_decode_pkg::WORD_DV];
    assign o_rx_er     = s.out_word[rx_decode_pkg::WORD_ER];
    assign o_rx_valid  = s.out_valid;
    assign o_crs       = s.crs;
    assign o_col       = s.col;

    assign fifo_out_ready = !s.out_valid || i_rx_ready;

    // decoded words buffered toward the mac side
    rx_nibble_fifo #(
        .WIDTH     (rx_decode_pkg::WORD_W),
        .DEPTH     (rx_decode_pkg::FIFO_DEPTH),
        .AF_MARGIN (rx_decode_pkg::FIFO_MARGIN)
    ) u_fifo (
        .i_mclk        (i_mclk),
        .i_reset_n     (i_reset_n),
        .i_in_valid    (push_valid),
        .i_in_data     (push_word),
        .o_in_ready    (fifo_in_ready),
        .o_almost_full (fifo_af),
        .o_out_valid   (fifo_out_valid),
        .o_out_data    (fifo_out_data),
        .i_out_ready   (fifo_out_ready)
    );

    // next state: sync, bit history, carrier, decode, output stage
    always_comb begin
        next_s     = s;
        push_valid = 1'b0;
        push_word  = '0;
        next_s.sync1 = {i_alt_invalid_map, i_repeater_ctrl, i_repeater_pin, i_tx_active, i_full_duplex};
        next_s.sync2 = s.sync1;
        fd   = s.sync2[rx_decode_pkg::SY_FULL_DPX];
        txa  = s.sync2[rx_decode_pkg::SY_TX_ACT];
        rptr = s.sync2[rx_decode_pkg::SY_RPT_PIN] || s.sync2[rx_decode_pkg::SY_RPT_CTRL];
        inv  = s.sync2[rx_decode_pkg::SY_ALT_INV] ? rx_decode_pkg::NIB_INV_ALT : rx_decode_pkg::NIB_INV_DEF;
        take     = i_rx_bit_strobe && s.bit_ready;
        new_sh   = {s.sh[rx_decode_pkg::HIST_W-2:0], i_rx_bit};
        grp      = new_sh[rx_decode_pkg::GROUP_W-1:0];
        dec      = rx_decode_pkg::decode_group(grp);
        boundary = take && (s.bitcnt == rx_decode_pkg::GROUP_LAST) && (s.st != rx_decode_pkg::ST_IDLE);
        // bit history and group position
        if (take) begin
            next_s.sh     = new_sh;
            next_s.bitcnt = (s.bitcnt == rx_decode_pkg::GROUP_LAST) ? rx_decode_pkg::GROUP_FIRST
                                                                   : s.bitcnt + rx_decode_pkg::GROUP_STEP;
            if (!s.carrier && !i_rx_bit && (new_sh[9:2] != 8'hFF)) begin
                next_s.carrier = 1'b1;
            end else if (new_sh[9:0] == {rx_decode_pkg::CODE_IDLE, rx_decode_pkg::CODE_IDLE}) begin
                next_s.carrier = 1'b0;
            end
        end
        // second word of a pair goes out one cycle later
        if (s.pend_valid) begin
            push_valid        = 1'b1;
            push_word         = s.pend_word;
            next_s.pend_valid = 1'b0;
        end
        unique case (s.st)
            rx_decode_pkg::ST_IDLE: begin
                if (take && new_sh == {rx_decode_pkg::CODE_IDLE, rx_decode_pkg::CODE_START_1,
                                       rx_decode_pkg::CODE_START_2}) begin
                    push_valid        = 1'b1;
                    push_word         = {1'b1, 1'b0, rx_decode_pkg::NIB_PREAMBLE};
                    next_s.pend_valid = 1'b1;
                    next_s.pend_word  = {1'b1, 1'b0, rx_decode_pkg::NIB_PREAMBLE};
                    next_s.st         = rx_decode_pkg::ST_DATA;
                    next_s.bitcnt     = rx_decode_pkg::GROUP_FIRST;
                    next_s.prev_idle  = 1'b0;
                end
            end
            rx_decode_pkg::ST_DATA: begin
                if (boundary) begin
                    next_s.prev_idle = (grp == rx_decode_pkg::CODE_IDLE);
                    if (s.prev_idle && grp == rx_decode_pkg::CODE_IDLE) begin
                        next_s.st = rx_decode_pkg::ST_IDLE;
                    end else if (grp == rx_decode_pkg::CODE_END_1) begin
                        next_s.st = rx_decode_pkg::ST_END_1;
                    end else if (dec[NIBBLE_IDX]) begin
                        push_valid = 1'b1;
                        push_word  = {1'b1, 1'b0, dec[3:0]};
                    end else begin
                        push_valid = 1'b1;
                        push_word  = {1'b1, 1'b1, inv};
                    end
                end
            end
            rx_decode_pkg::ST_END_1: begin
                if (boundary) begin
                    if (grp == rx_decode_pkg::CODE_END_2) begin
                        next_s.st = rx_decode_pkg::ST_IDLE;
                    end else begin
                        push_valid        = 1'b1;
                        push_word         = {1'b1, 1'b1, inv};
                        next_s.pend_valid = 1'b1;
                        next_s.pend_word  = dec[NIBBLE_IDX] ? {1'b1, 1'b0, dec[3:0]} : {1'b1, 1'b1, inv};
                        next_s.prev_idle  = (grp == rx_decode_pkg::CODE_IDLE);
                        next_s.st         = rx_decode_pkg::ST_DATA;
                    end
                end
            end
            default: begin
                next_s.st = rx_decode_pkg::ST_IDLE;
            end
        endcase
        // carrier and collision toward the mac
        next_s.crs = next_s.carrier || (txa && !fd && !rptr);
        next_s.col = !fd && s.carrier && txa;
        // stall the bit source before the fifo can overflow
        next_s.bit_ready = !fifo_af;
        // output register stage
        if (fifo_out_ready) begin
            next_s.out_valid = fifo_out_valid;
            if (fifo_out_valid) begin
                next_s.out_word = fifo_out_data;
            end
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s    <= '0;
            s.st <= rx_decode_pkg::ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    // checks on the decode path
    sequence s_start_pair;
        s.st == rx_decode_pkg::ST_IDLE && take && new_sh == {rx_decode_pkg::CODE_IDLE,
            rx_decode_pkg::CODE_START_1, rx_decode_pkg::CODE_START_2};
    endsequence
    sequence s_two_preambles;
        (push_valid && push_word == {1'b1, 1'b0, rx_decode_pkg::NIB_PREAMBLE}) [*2];
    endsequence
    property p_preamble;
        s_start_pair |-> s_two_preambles ##0 (s.st == rx_decode_pkg::ST_DATA);
    endproperty
    a_preamble: assert property (p_preamble) else $error("start pair not replaced by preamble");

    property p_inv_default;
        boundary && s.st == rx_decode_pkg::ST_DATA && !dec[NIBBLE_IDX] && grp != rx_decode_pkg::CODE_END_1
            && grp != rx_decode_pkg::CODE_IDLE && !s.sync2[rx_decode_pkg::SY_ALT_INV]
            |-> push_valid && push_word == {1'b1, 1'b1, rx_decode_pkg::NIB_INV_DEF};
    endproperty
    a_inv_default: assert property (p_inv_default) else $error("invalid group not mapped to 6");

    property p_inv_alt;
        boundary && s.st == rx_decode_pkg::ST_DATA && !dec[NIBBLE_IDX] && grp != rx_decode_pkg::CODE_END_1
            && grp != rx_decode_pkg::CODE_IDLE && s.sync2[rx_decode_pkg::SY_ALT_INV]
            |-> push_valid && push_word == {1'b1, 1'b1, rx_decode_pkg::NIB_INV_ALT};
    endproperty
    a_inv_alt: assert property (p_inv_alt) else $error("invalid group not mapped to 5");

    property p_ctrl_in_data;
        boundary && s.st == rx_decode_pkg::ST_DATA
            && (grp == rx_decode_pkg::CODE_START_1 || grp == rx_decode_pkg::CODE_START_2)
            |-> push_valid && push_word[rx_decode_pkg::WORD_ER];
    endproperty
    a_ctrl_in_data: assert property (p_ctrl_in_data) else $error("control group in data without error");

    property p_decode;
        boundary && s.st == rx_decode_pkg::ST_DATA && dec[NIBBLE_IDX]
            |-> push_valid && push_word == {1'b1, 1'b0, dec[3:0]};
    endproperty
    a_decode: assert property (p_decode) else $error("data group decoded wrongly");

    property p_end_pair;
        boundary && s.st == rx_decode_pkg::ST_END_1 && grp == rx_decode_pkg::CODE_END_2
            |-> !push_valid ##1 (s.st == rx_decode_pkg::ST_IDLE && !push_valid);
    endproperty
    a_end_pair: assert property (p_end_pair) else $error("end pair did not stop decoding");

    property p_col_half;
        !fd && s.carrier && txa |=> o_col;
    endproperty
    a_col_half: assert property (p_col_half) else $error("collision not reported");

    property p_col_full;
        fd |=> !o_col;
    endproperty
    a_col_full: assert property (p_col_full) else $error("collision in full duplex");

    property p_crs_set;
        take && !s.carrier && !i_rx_bit && new_sh[9:2] != 8'hFF |=> s.carrier && o_crs;
    endproperty
    a_crs_set: assert property (p_crs_set) else $error("carrier not raised");

    property p_crs_tx_half;
        txa && !fd && !rptr |=> o_crs;
    endproperty
    a_crs_tx_half: assert property (p_crs_tx_half) else $error("no carrier during half duplex transmit");

    property p_crs_full;
        (fd || rptr) && !next_s.carrier |=> !o_crs;
    endproperty
    a_crs_full: assert property (p_crs_full) else $error("carrier from transmit in full duplex or repeater");

    property p_crs_clear;
        take && s.carrier && new_sh[9:0] == 10'h3FF |=> !s.carrier;
    endproperty
    a_crs_clear: assert property (p_crs_clear) else $error("idle pair did not drop carrier");

    property p_no_overflow;
        push_valid |-> fifo_in_ready;
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("word pushed into full fifo");

    property p_align;
        s_start_pair |=> s.bitcnt == rx_decode_pkg::GROUP_FIRST;
    endproperty
    a_align: assert property (p_align) else $error("group boundary not fixed by start pair");

endmodule // fast_eth_rx_symbol_decode

`default_nettype wire

// File: rtl/rx_nibble_fifo.sv
// synchronous fifo for decoded receive words
`timescale 1ns/1ps
`default_nettype none

module rx_nibble_fifo #(
    parameter int WIDTH     = 6,
    parameter int DEPTH     = 16,
    parameter int AF_MARGIN = 3
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_almost_full,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               count;
    } fifo_s;

    fifo_s s;
    fifo_s next_s;
    logic  do_wr;
    logic  do_rd;

    // flags straight from the fill count
    assign o_in_ready    = (s.count != CW'(DEPTH));
    assign o_out_valid   = (s.count != '0);
    assign o_out_data    = s.mem[s.rd];
    assign o_almost_full = (s.count >= CW'(DEPTH - AF_MARGIN));

    // pointer and storage update
    always_comb begin
        next_s = s;
        do_wr  = i_in_valid && o_in_ready;
        do_rd  = i_out_ready && o_out_valid;
        if (do_wr) begin
            next_s.mem[s.wr] = i_in_data;
            next_s.wr        = s.wr + PW'(1);
        end
        if (do_rd) begin
            next_s.rd = s.rd + PW'(1);
        end
        next_s.count = s.count + CW'(do_wr) - CW'(do_rd);
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule // rx_nibble_fifo

`default_nettype wire

// File: shared/rx_decode_pkg.sv
// constants and lookup for the 100 Mb/s receive symbol decoder
package rx_decode_pkg;

    // code group geometry
    localparam int          GROUP_W      = 5;
    localparam int          NIBBLE_W     = 4;
    localparam int          HIST_W       = 15;
    localparam logic [2:0]  GROUP_LAST   = 3'h4;
    localparam logic [2:0]  GROUP_FIRST  = 3'h0;
    localparam logic [2:0]  GROUP_STEP   = 3'h1;

    // control code groups
    localparam logic [4:0]  CODE_IDLE    = 5'h1F;
    localparam logic [4:0]  CODE_START_1 = 5'h18;
    localparam logic [4:0]  CODE_START_2 = 5'h11;
    localparam logic [4:0]  CODE_END_1   = 5'h0D;
    localparam logic [4:0]  CODE_END_2   = 5'h07;

    // nibbles substituted by the decoder
    localparam logic [3:0]  NIB_PREAMBLE = 4'hA;
    localparam logic [3:0]  NIB_INV_DEF  = 4'h6;
    localparam logic [3:0]  NIB_INV_ALT  = 4'h5;

    // word carried through the fifo: {data valid, error, nibble}
    localparam int          WORD_W       = 6;
    localparam int          WORD_DV      = 5;
    localparam int          WORD_ER      = 4;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          FIFO_MARGIN  = 3;

    // synchronised pin inputs, bit positions
    localparam int          SYNC_W       = 5;
    localparam int          SY_FULL_DPX  = 0;
    localparam int          SY_TX_ACT    = 1;
    localparam int          SY_RPT_PIN   = 2;
    localparam int          SY_RPT_CTRL  = 3;
    localparam int          SY_ALT_INV   = 4;

    // receive control states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DATA  = 2'b01,
        ST_END_1 = 2'b10
    } rx_state_e;

    // code group to {valid, nibble}
    function automatic logic [4:0] decode_group(input logic [4:0] grp);
        logic [4:0] res;
        res = 5'h00;
        unique case (grp)
            5'h1E: res = 5'h10;
            5'h09: res = 5'h11;
            5'h14: res = 5'h12;
            5'h15: res = 5'h13;
            5'h0A: res = 5'h14;
            5'h0B: res = 5'h15;
            5'h0E: res = 5'h16;
            5'h0F: res = 5'h17;
            5'h12: res = 5'h18;
            5'h13: res = 5'h19;
            5'h16: res = 5'h1A;
            5'h17: res = 5'h1B;
            5'h1A: res = 5'h1C;
            5'h1B: res = 5'h1D;
            5'h1C: res = 5'h1E;
            5'h1D: res = 5'h1F;
            default: res = 5'h00;
        endcase
        return res;
    endfunction

endpackage

// File: testbench/fast_eth_rx_symbol_decode_test.sv
// self-checking bench for the receive symbol decoder
`timescale 1ns/1ps
`default_nettype none

module fast_eth_rx_symbol_decode_test;
    logic       i_mclk = 1'b0;
    logic       i_reset_n = 1'b0;
    logic       rx_bit = 1'b0;
    logic       strobe = 1'b0;
    logic       fdx = 1'b0;
    logic       tx = 1'b0;
    logic       rp = 1'b0;
    logic       rc = 1'b0;
    logic       alt = 1'b0;
    logic       stall = 1'b0;
    logic       bit_ready, rx_dv, rx_er, rx_valid, crs, col, rx_ready;
    logic [3:0] rxd;
    int         fail_count = 0;
    int         num_checks = 0;
    logic [6:0] exp_q[$];
    logic [4:0] enc[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

    fast_eth_rx_symbol_decode uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_rx_bit(rx_bit),
        .i_rx_bit_strobe(strobe), .i_full_duplex(fdx), .i_tx_active(tx), .i_repeater_pin(rp),
        .i_repeater_ctrl(rc), .i_alt_invalid_map(alt), .i_rx_ready(rx_ready), .o_bit_ready(bit_ready),
        .o_rxd(rxd), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_rx_valid(rx_valid), .o_crs(crs), .o_col(col));

    mac_rx_model mac (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_stall(stall), .i_valid(rx_valid),
        .i_dv(rx_dv), .i_er(rx_er), .i_rxd(rxd), .o_ready(rx_ready));

    // free running 100 MHz clock
    initial forever #5 i_mclk = ~i_mclk;

    task automatic check(input logic [5:0] seen, input logic [5:0] want);
        num_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // one code group, first bit first, each bit held until taken
    task automatic grp(input logic [4:0] v);
        logic r;
        for (int i = 4; i >= 0; i--) begin
            rx_bit <= v[i];
            strobe <= 1'b1;
            do begin
                @(negedge i_mclk) r = bit_ready;
                @(posedge i_mclk);
            end while (r !== 1'b1);
        end
    endtask

    task automatic start_pkt();
        grp(5'h1F); grp(5'h1F); grp(5'h18); grp(5'h11);
        exp_q.push_back(7'h2A); exp_q.push_back(7'h2A);
    endtask

    task automatic data(input int n);
        grp(enc[n]);
        exp_q.push_back({3'b010, 4'(n)});
    endtask

    // error word, data valid not judged
    task automatic bad(input logic [4:0] g, input logic [3:0] nib);
        grp(g);
        exp_q.push_back({3'b111, nib});
    endtask

    task automatic end_pkt();
        grp(5'h0D); grp(5'h07); grp(5'h1F); grp(5'h1F);
    endtask

    // compare the words the mac took against the expected list
    task automatic check_rx();
        logic [5:0] m;
        strobe <= 1'b0;
        for (int k = 0; k < 300 && mac.words.size() < exp_q.size(); k++) @(posedge i_mclk);
        wait_cyc(4);
        check(6'(mac.words.size()), 6'(exp_q.size()));
        for (int k = 0; k < exp_q.size() && k < mac.words.size(); k++) begin
            m = exp_q[k][6] ? 6'h20 : 6'h00;
            check(mac.words[k] | m, exp_q[k][5:0] | m);
        end
        mac.words.delete();
        exp_q.delete();
    endtask

    task automatic t_decode();
        start_pkt();
        check({5'h00, crs}, 6'h01);
        for (int n = 0; n < 16; n++) data(n);
        end_pkt();
        strobe <= 1'b0;
        wait_cyc(12);
        check({5'h00, crs}, 6'h00);
        check_rx();
    endtask

    task automatic t_invalid();
        start_pkt();
        bad(5'h00, 4'h6);
        data(3);
        bad(5'h1F, 4'h6);
        data(5);
        bad(5'h18, 4'h6);
        bad(5'h11, 4'h6);
        bad(5'h0D, 4'h6);
        data(9);
        end_pkt();
        check_rx();
        alt <= 1'b1;
        wait_cyc(4);
        start_pkt();
        bad(5'h10, 4'h5);
        bad(5'h1F, 4'h5);
        data(8);
        end_pkt();
        check_rx();
        alt <= 1'b0;
        wait_cyc(4);
    endtask

    task automatic t_idle_end();
        start_pkt();
        data(1);
        bad(5'h1F, 4'h6);
        grp(5'h1F);
        strobe <= 1'b0;
        wait_cyc(12);
        check({5'h00, crs}, 6'h00);
        check_rx();
    endtask

    task automatic t_col();
        start_pkt();
        data(2);
        tx <= 1'b1;
        data(7);
        check({4'h0, crs, col}, 6'h03);
        end_pkt();
        strobe <= 1'b0;
        wait_cyc(12);
        check({4'h0, crs, col}, 6'h02);
        tx <= 1'b0;
        wait_cyc(5);
        check({4'h0, crs, col}, 6'h00);
        check_rx();
    endtask

    task automatic t_fdx();
        fdx <= 1'b1;
        wait_cyc(4);
        start_pkt();
        tx <= 1'b1;
        data(4);
        check({4'h0, crs, col}, 6'h02);
        end_pkt();
        strobe <= 1'b0;
        wait_cyc(12);
        check({4'h0, crs, col}, 6'h00);
        tx <= 1'b0;
        fdx <= 1'b0;
        wait_cyc(4);
        check_rx();
    endtask

    task automatic t_repeater();
        for (int m = 0; m < 2; m++) begin
            rp <= (m == 0);
            rc <= (m == 1);
            tx <= 1'b1;
            wait_cyc(6);
            check({4'h0, crs, col}, 6'h00);
            tx <= 1'b0;
            rp <= 1'b0;
            rc <= 1'b0;
            wait_cyc(4);
        end
    endtask

    // fill the fifo while the mac stalls, then drain it
    task automatic t_fifo();
        stall <= 1'b1;
        start_pkt();
        for (int n = 0; n < 12; n++) data(n);
        // ready is still high for one edge after the fill crosses the mark
        strobe <= 1'b0;
        wait_cyc(1);
        rx_bit <= 1'b0;
        strobe <= 1'b1;
        wait_cyc(6);
        @(negedge i_mclk) check({5'h00, bit_ready}, 6'h00);
        wait_cyc(1);
        wait_cyc(3);
        strobe <= 1'b0;
        stall <= 1'b0;
        wait_cyc(1);
        data(12);
        end_pkt();
        check_rx();
        @(negedge i_mclk) check({5'h00, bit_ready}, 6'h01);
        wait_cyc(1);
    endtask

    // main sequence
    initial begin
        wait_cyc(20);
        i_reset_n <= 1'b1;
        wait_cyc(2);
        @(negedge i_mclk) check({2'b00, bit_ready, rx_valid, crs, col}, 6'h08);
        wait_cyc(1);
        t_decode();
        t_invalid();
        t_idle_end();
        t_col();
        t_fdx();
        t_repeater();
        t_fifo();
        give_verdict();
    end

    // watchdog against a hung handshake
    initial begin
        #300us;
        fail_count++;
        give_verdict();
    end
endmodule // fast_eth_rx_symbol_decode_test

`default_nettype wire

// File: testbench/mac_rx_model.sv
// mac side model that accepts decoded receive words
`timescale 1ns/1ps
`default_nettype none

module mac_rx_model (
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    input  wire logic       i_stall,
    input  wire logic       i_valid,
    input  wire logic       i_dv,
    input  wire logic       i_er,
    input  wire logic [3:0] i_rxd,
    output logic            o_ready
);
    logic [5:0] words[$];

    // ready follows the stall request one cycle later
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) o_ready <= 1'b0;
        else            o_ready <= !i_stall;
    end

    // store every word taken, in arrival order
    always @(posedge i_mclk) begin
        if (i_reset_n && i_valid && o_ready) words.push_back({i_dv, i_er, i_rxd});
    end
endmodule // mac_rx_model

`default_nettype wire
